// *** verilog/mpr_regmap.sv ***
// paged register bank of a two-channel metering core, with APB access
// What this block does
// - page register at index 31 writable from any page, never read back
// - internal address is page value above the 5-bit command index
// - 128 pages of 32 locations, page value selects active page
// - reset loads documented defaults; page starts at zero
// - config 23:16 signed phase shift of channel 1 voltage, -1 to <1 sample
// - config bit 15 makes both pulse pins open-drain, else push-pull
// - config 12:11 pick interrupt pin level low/high or pulse low/high
// - config bit 4 inverts host clock output
// - config 3:0 divide master clock by 1..16, zero means 16, reset 1
// - instantaneous current and voltage are signed 24-bit fractions
// - instantaneous power is product of channel voltage and current
// - active power is instantaneous power averaged over N samples
// - RMS current and voltage per interval as unsigned fractions
// - quadrature power is current times 90-degree shifted voltage
// - reactive power is quadrature power averaged over N samples
// - read of index 31 returns reactive pulse value on page 0, zero on other pages; write sets page
// - interval length N comes from cycle count register
`timescale 1ns/1ps
`include "mpr_defines.svh"

module mpr_regmap
    import mpr_pkg::*;
#(
    parameter int CNT_W = 24
) (
    input wire logic i_sys_clk, // master clock
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error, unmapped location
    input wire logic i_smp_valid, // one output-word-rate sample set
    input wire mpr_chan_smp_type [1:0] i_smp, // samples, index 0 is channel 1
    input wire mpr_word_type i_reactive_pulse_value, // reactive pulse value
    input wire logic i_pulse_a_n, // pulse a request, active low
    input wire logic i_pulse_b_n, // pulse b request, active low
    output logic o_pulse_out_a, // pulse pin a output value
    output logic o_pulse_out_a_oe, // pulse pin a drive enable
    output logic o_pulse_out_b, // pulse pin b output value
    output logic o_pulse_out_b_oe, // pulse pin b drive enable
    input wire logic i_irq_req, // pending interrupt level
    output logic o_irq, // interrupt pin
    output logic o_internal_tick, // internal clock enable, one per K cycles
    output logic o_host_clk_out, // clock to host processor
    output logic o_interval_done // pulse when low-rate results update
);

    logic [`MPR_PAGE_W-1:0] page_q;
    logic [23:0] cfg_q;
    logic [CNT_W-1:0] n_q;
    logic [`MPR_IDX_W-1:0] idx;
    logic [`MPR_PAGE_W+`MPR_IDX_W-1:0] int_addr;
    logic wr_acc;
    logic [23:0] rd_d;
    logic err_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    mpr_chan_res_type res_q [2];
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] n_eff;
    logic last;
    logic done_q;

    assign idx = i_paddr[6:2];
    assign int_addr = {page_q, idx};
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;

    // host registers; writes land on the access edge
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            page_q <= `MPR_PAGE_RESET;
            cfg_q <= `MPR_CONFIG_RESET;
            n_q <= CNT_W'(`MPR_CYCLE_COUNT_RESET);
        end else if (wr_acc) begin
            if (idx == `MPR_IDX_PAGE) begin
                page_q <= i_pwdata[`MPR_PAGE_W-1:0];
            end else if (int_addr == {`MPR_PAGE_RESULTS, `MPR_IDX_CONFIG}) begin
                cfg_q <= i_pwdata[23:0] & `MPR_CONFIG_WMASK;
            end else if (int_addr == {`MPR_PAGE_CALIB, `MPR_IDX_CYCLE_COUNT}) begin
                n_q <= i_pwdata[CNT_W-1:0];
            end
        end
    end

    always_comb begin
        rd_d = '0;
        err_d = 1'b0;
        if (idx == `MPR_IDX_PAGE) begin
            // the page register itself never reads back
            if (page_q == `MPR_PAGE_RESULTS) begin
                rd_d = i_reactive_pulse_value;
            end
        end else if (page_q == `MPR_PAGE_RESULTS) begin
            case (idx)
                `MPR_IDX_CONFIG: rd_d = cfg_q;
                `MPR_IDX_CUR_CH1: rd_d = res_q[0].cur;
                `MPR_IDX_VOLT_CH1: rd_d = res_q[0].volt;
                `MPR_IDX_PWR_CH1: rd_d = res_q[0].inst_p;
                `MPR_IDX_AVG_P_CH1: rd_d = res_q[0].avg_p;
                `MPR_IDX_RMS_I_CH1: rd_d = res_q[0].rms_i;
                `MPR_IDX_RMS_V_CH1: rd_d = res_q[0].rms_v;
                `MPR_IDX_CUR_CH2: rd_d = res_q[1].cur;
                `MPR_IDX_VOLT_CH2: rd_d = res_q[1].volt;
                `MPR_IDX_PWR_CH2: rd_d = res_q[1].inst_p;
                `MPR_IDX_AVG_P_CH2: rd_d = res_q[1].avg_p;
                `MPR_IDX_RMS_I_CH2: rd_d = res_q[1].rms_i;
                `MPR_IDX_RMS_V_CH2: rd_d = res_q[1].rms_v;
                `MPR_IDX_AVG_Q_CH1: rd_d = res_q[0].avg_q;
                `MPR_IDX_QUAD_CH1: rd_d = res_q[0].inst_q;
                `MPR_IDX_AVG_Q_CH2: rd_d = res_q[1].avg_q;
                `MPR_IDX_QUAD_CH2: rd_d = res_q[1].inst_q;
                default: err_d = 1'b1;
            endcase
        end else if (int_addr == {`MPR_PAGE_CALIB, `MPR_IDX_CYCLE_COUNT}) begin
            rd_d = 24'(n_q);
        end else begin
            err_d = 1'b1;
        end
    end

    // read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (i_psel && !i_penable) begin
            prdata_q <= i_pwrite ? 32'h00000000 : {8'h00, rd_d};
            pslverr_q <= err_d;
        end
    end

    // fractional-delay interpolation between this sample and the previous one
    function automatic mpr_word_type interp(input mpr_word_type now_s, input mpr_word_type prev_s,
                                            input logic [7:0] frac);
        logic signed [24:0] diff;
        logic signed [33:0] prod;
        logic [24:0] sum;
        diff = 25'(prev_s) - 25'(now_s);
        prod = diff * $signed({1'b0, frac});
        sum = 25'(now_s) + prod[31:7];
        return sum[23:0];
    endfunction : interp

    function automatic mpr_word_type fmul(input mpr_word_type a, input mpr_word_type b);
        logic signed [47:0] m;
        m = a * b;
        // -1 times -1 is the only product that leaves the range
        return (m[47:46] == 2'b01) ? `MPR_FRAC_MAX : m[46:23];
    endfunction : fmul

    function automatic logic [23:0] isqrt(input logic [47:0] x);
        logic [23:0] r;
        logic [47:0] t;
        r = '0;
        for (int b = 23; b >= 0; b--) begin
            t = {24'h000000, r | (24'h000001 << b)};
            if (t * t <= x) begin
                r = r | (24'h000001 << b);
            end
        end
        return r;
    endfunction : isqrt

    assign n_eff = (n_q == '0) ? CNT_W'(1) : n_q;
    assign last = (cnt_q >= n_eff - CNT_W'(1));

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= i_smp_valid && last;
            if (i_smp_valid) begin
                cnt_q <= last ? '0 : cnt_q + CNT_W'(1);
            end
        end
    end
    assign o_interval_done = done_q;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        mpr_word_type prev_i_q;
        mpr_word_type prev_v_q;
        mpr_word_type cur;
        mpr_word_type volt;
        mpr_word_type p_now;
        mpr_word_type q_now;
        logic [47:0] sq_i;
        logic [47:0] sq_v;
        logic [7:0] ph_mag;
        logic signed [CNT_W+23:0] acc_p_q;
        logic signed [CNT_W+23:0] acc_q_q;
        logic [CNT_W+47:0] acc_i_q;
        logic [CNT_W+47:0] acc_v_q;
        logic signed [CNT_W+23:0] sum_p;
        logic signed [CNT_W+23:0] sum_q;
        logic [CNT_W+47:0] sum_i;
        logic [CNT_W+47:0] sum_v;
        logic signed [CNT_W+23:0] avg_p;
        logic signed [CNT_W+23:0] avg_q;
        logic [CNT_W+47:0] msq_i;
        logic [CNT_W+47:0] msq_v;
        logic [47:0] x_i;
        logic [47:0] x_v;

        always_comb begin
            ph_mag = cfg_q[`MPR_CFG_PHASE_HI] ? 8'(-cfg_q[`MPR_CFG_PHASE_HI:`MPR_CFG_PHASE_LO])
                                              : cfg_q[`MPR_CFG_PHASE_HI:`MPR_CFG_PHASE_LO];
            cur = i_smp[c].cur;
            volt = i_smp[c].volt;
            // a negative shift would need a future voltage, so the current is delayed instead
            if (c == 0 && !cfg_q[`MPR_CFG_PHASE_HI]) begin
                volt = interp(i_smp[c].volt, prev_v_q, ph_mag);
            end else if (c == 0) begin
                cur = interp(i_smp[c].cur, prev_i_q, ph_mag);
            end
            p_now = fmul(volt, cur);
            q_now = fmul(i_smp[c].volt_q, cur);
            sq_i = 48'(cur * cur);
            sq_v = 48'(volt * volt);
            sum_p = acc_p_q + (CNT_W+24)'(p_now);
            sum_q = acc_q_q + (CNT_W+24)'(q_now);
            sum_i = acc_i_q + (CNT_W+48)'(sq_i);
            sum_v = acc_v_q + (CNT_W+48)'(sq_v);
            avg_p = sum_p / $signed({1'b0, n_eff});
            avg_q = sum_q / $signed({1'b0, n_eff});
            msq_i = sum_i / (CNT_W+48)'(n_eff);
            msq_v = sum_v / (CNT_W+48)'(n_eff);
            // mean square is a Q46 value; shift to Q48 so the root lands in Q24
            x_i = msq_i[46] ? `MPR_SQ_MAX : {msq_i[45:0], 2'b00};
            x_v = msq_v[46] ? `MPR_SQ_MAX : {msq_v[45:0], 2'b00};
        end

        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                prev_i_q <= '0;
                prev_v_q <= '0;
                acc_p_q <= '0;
                acc_q_q <= '0;
                acc_i_q <= '0;
                acc_v_q <= '0;
                res_q[c] <= '0;
            end else if (i_smp_valid) begin
                prev_i_q <= i_smp[c].cur;
                prev_v_q <= i_smp[c].volt;
                // instantaneous fields load every sample; averaged and RMS fields all load together on the last-sample edge
                res_q[c].cur <= cur;
                res_q[c].volt <= volt;
                res_q[c].inst_p <= p_now;
                res_q[c].inst_q <= q_now;
                if (last) begin
                    acc_p_q <= '0;
                    acc_q_q <= '0;
                    acc_i_q <= '0;
                    acc_v_q <= '0;
                    res_q[c].avg_p <= avg_p[23:0];
                    res_q[c].avg_q <= avg_q[23:0];
                    res_q[c].rms_i <= isqrt(x_i);
                    res_q[c].rms_v <= isqrt(x_v);
                end else begin
                    acc_p_q <= sum_p;
                    acc_q_q <= sum_q;
                    acc_i_q <= sum_i;
                    acc_v_q <= sum_v;
                end
            end
        end
    end

    // master clock divider; K of 1 leaves the host clock a steady level
    logic [4:0] k_val;
    logic [4:0] div_q;
    logic tick_q;
    logic hclk_q;
    assign k_val = (cfg_q[`MPR_CFG_DIV_HI:0] == 4'h0) ? `MPR_DIV_ZERO_VALUE : {1'b0, cfg_q[`MPR_CFG_DIV_HI:0]};

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
            hclk_q <= 1'b0;
        end else begin
            div_q <= (div_q >= k_val - 5'h01) ? 5'h00 : div_q + 5'h01;
            tick_q <= (div_q >= k_val - 5'h01);
            hclk_q <= (div_q < ((k_val + 5'h01) >> 1)) ^ cfg_q[`MPR_CFG_HCLK_INV];
        end
    end
    assign o_internal_tick = tick_q;
    assign o_host_clk_out = hclk_q;

    logic irq_prev_q;
    logic [7:0] irq_cnt_q;
    logic irq_q;
    logic irq_active;
    assign irq_active = cfg_q[`MPR_CFG_IRQ_PULSE] ? (irq_cnt_q != 8'h00) : i_irq_req;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_prev_q <= 1'b0;
            irq_cnt_q <= '0;
            irq_q <= 1'b1;
        end else begin
            irq_prev_q <= i_irq_req;
            if (i_irq_req && !irq_prev_q) begin
                irq_cnt_q <= 8'(`MPR_IRQ_PULSE_CYC);
            end else if (irq_cnt_q != 8'h00) begin
                irq_cnt_q <= irq_cnt_q - 8'h01;
            end
            irq_q <= cfg_q[`MPR_CFG_IRQ_POL] ? irq_active : !irq_active;
        end
    end
    assign o_irq = irq_q;

    logic [3:0] pins_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pins_q <= 4'hF;
        end else if (cfg_q[`MPR_CFG_OPEN_DRAIN]) begin
            // open drain: pull low while asserted, release otherwise
            pins_q <= {1'b0, !i_pulse_b_n, 1'b0, !i_pulse_a_n};
        end else begin
            pins_q <= {i_pulse_b_n, 1'b1, i_pulse_a_n, 1'b1};
        end
    end
    assign o_pulse_out_a = pins_q[1];
    assign o_pulse_out_a_oe = pins_q[0];
    assign o_pulse_out_b = pins_q[3];
    assign o_pulse_out_b_oe = pins_q[2];

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    property p_page_write;
        wr_acc && idx == `MPR_IDX_PAGE |=> page_q == $past(i_pwdata[6:0]);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");
    property p_page_read;
        i_psel && !i_penable && !i_pwrite && idx == `MPR_IDX_PAGE && page_q == `MPR_PAGE_RESULTS
            |=> o_prdata == {8'h00, $past(i_reactive_pulse_value)};
    endproperty
    a_page_read: assert property (p_page_read) else $error("index 31 read wrong");
    property p_paged_read;
        i_psel && !i_penable && !i_pwrite && int_addr == {`MPR_PAGE_CALIB, `MPR_IDX_CYCLE_COUNT}
            |=> o_prdata[CNT_W-1:0] == n_q && !o_pslverr;
    endproperty
    a_paged_read: assert property (p_paged_read) else $error("paged read wrong");
    property p_defaults;
        $past(i_rst) |-> page_q == `MPR_PAGE_RESET && cfg_q == `MPR_CONFIG_RESET;
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset defaults wrong");
    property p_open_drain;
        cfg_q[`MPR_CFG_OPEN_DRAIN] && !i_pulse_a_n ##1 $stable(cfg_q) |-> o_pulse_out_a_oe && !o_pulse_out_a;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pin wrong");
    property p_irq_pulse;
        $rose(i_irq_req) && cfg_q[`MPR_CFG_IRQ_PULSE] ##1 $stable(cfg_q) [*2]
            |-> o_irq == cfg_q[`MPR_CFG_IRQ_POL];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse missing");
    property p_div_range;
        $stable(k_val) |-> div_q < k_val || $past(div_q) >= $past(k_val) - 5'h01;
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider out of range");
    property p_inst_power;
        i_smp_valid |=> res_q[1].inst_p == fmul($past(i_smp[1].volt), $past(i_smp[1].cur));
    endproperty
    a_inst_power: assert property (p_inst_power) else $error("power product wrong");
    property p_interval;
        i_smp_valid && last |=> cnt_q == '0 && o_interval_done;
    endproperty
    a_interval: assert property (p_interval) else $error("interval wrap wrong");
    property p_atomic;
        !$past(i_smp_valid && last) |-> $stable(res_q[0].avg_p) && $stable(res_q[1].rms_v);
    endproperty
    a_atomic: assert property (p_atomic) else $error("result changed off interval");

    c_interval: cover property (i_smp_valid && last);
    c_page_switch: cover property (wr_acc && idx == `MPR_IDX_PAGE && i_pwdata[6:0] != 7'h00);
    c_irq_pulse: cover property ($rose(i_irq_req) && cfg_q[`MPR_CFG_IRQ_PULSE]);

endmodule : mpr_regmap

// *** verilog/mpr_defines.svh ***
// register indices, field positions, reset values and timing counts of the metering register bank
`ifndef MPR_DEFINES_SVH
`define MPR_DEFINES_SVH

`define MPR_PAGE_W 7
`define MPR_IDX_W 5
`define MPR_IDX_CONFIG 5'h00
`define MPR_IDX_CUR_CH1 5'h01
`define MPR_IDX_VOLT_CH1 5'h02
`define MPR_IDX_PWR_CH1 5'h03
`define MPR_IDX_AVG_P_CH1 5'h04
`define MPR_IDX_RMS_I_CH1 5'h05
`define MPR_IDX_RMS_V_CH1 5'h06
`define MPR_IDX_CUR_CH2 5'h07
`define MPR_IDX_VOLT_CH2 5'h08
`define MPR_IDX_PWR_CH2 5'h09
`define MPR_IDX_AVG_P_CH2 5'h0A
`define MPR_IDX_RMS_I_CH2 5'h0B
`define MPR_IDX_RMS_V_CH2 5'h0C
`define MPR_IDX_AVG_Q_CH1 5'h0D
`define MPR_IDX_QUAD_CH1 5'h0E
`define MPR_IDX_AVG_Q_CH2 5'h10
`define MPR_IDX_QUAD_CH2 5'h11
`define MPR_IDX_CYCLE_COUNT 5'h13
`define MPR_IDX_PAGE 5'h1F
`define MPR_PAGE_RESULTS 7'h00
`define MPR_PAGE_CALIB 7'h01
`define MPR_PAGE_RESET 7'h00
`define MPR_CONFIG_RESET 24'h000001
`define MPR_CONFIG_WMASK 24'hFF981F
`define MPR_CYCLE_COUNT_RESET 24'h000FA0
`define MPR_CFG_PHASE_HI 23
`define MPR_CFG_PHASE_LO 16
`define MPR_CFG_OPEN_DRAIN 15
`define MPR_CFG_IRQ_PULSE 12
`define MPR_CFG_IRQ_POL 11
`define MPR_CFG_HCLK_INV 4
`define MPR_CFG_DIV_HI 3
`define MPR_DIV_ZERO_VALUE 5'h10
`define MPR_FRAC_MAX 24'h7FFFFF
`define MPR_SQ_MAX 48'hFFFFFFFFFFFF
`define MPR_CLK_NS 40
`define MPR_IRQ_PULSE_NS 1000
`define MPR_IRQ_PULSE_CYC ((`MPR_IRQ_PULSE_NS + `MPR_CLK_NS - 1) / `MPR_CLK_NS)

`endif

// *** verilog/mpr_pkg.sv ***
// types shared by the metering register bank
package mpr_pkg;
    typedef logic signed [23:0] mpr_word_type;
    typedef struct packed {
        mpr_word_type cur;
        mpr_word_type volt;
        mpr_word_type volt_q;
    } mpr_chan_smp_type;
    typedef struct packed {
        mpr_word_type cur;
        mpr_word_type volt;
        mpr_word_type inst_p;
        mpr_word_type inst_q;
        mpr_word_type avg_p;
        mpr_word_type avg_q;
        logic [23:0] rms_i;
        logic [23:0] rms_v;
    } mpr_chan_res_type;
endpackage : mpr_pkg

// *** test/mpr_host_model.sv ***
// apb master model of the host controller
`timescale 1ns/1ps
`include "mpr_defines.svh"
module mpr_host_model (
    input wire logic i_sys_clk, // clock
    input wire logic [31:0] i_prdata, // read data
    input wire logic i_pready, // ready
    input wire logic i_pslverr, // error
    output logic o_psel, // select
    output logic o_penable, // enable
    output logic o_pwrite, // direction
    output logic [7:0] o_paddr, // byte address
    output logic [31:0] o_pwdata // write data
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end
    task xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd, output logic [31:0] rd,
              output logic err);
        @(posedge i_sys_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= {1'b0, idx, 2'b00};
        // undefined config bits are never written as one
        o_pwdata <= (idx == `MPR_IDX_CONFIG) ? (wd & {8'h00, `MPR_CONFIG_WMASK}) : wd;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        do @(posedge i_sys_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // released lines flip so no stale value looks valid
        o_paddr <= ~o_paddr;
        o_pwdata <= ~o_pwdata;
    endtask : xfer
endmodule : mpr_host_model

// *** test/testbench.sv ***
// self-checking bench of the metering register bank
`timescale 1ns/1ps
`include "mpr_defines.svh"
module testbench;
    import mpr_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic i_smp_valid = 1'b0;
    mpr_chan_smp_type [1:0] i_smp = '0;
    mpr_word_type pulse_val = 24'h5A3C71;
    logic i_pulse_a_n = 1'b0;
    logic i_pulse_b_n = 1'b1;
    logic i_irq_req = 1'b0;
    logic pa, pa_oe, pb, pb_oe, irq, tick, hclk, done;
    int errors = 0;
    int n_tests = 0;
    int n_done = 0;
    always #20 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (done === 1'b1) n_done <= n_done + 1;
    mpr_regmap mpr_regmap_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_smp_valid(i_smp_valid), .i_smp(i_smp), .i_reactive_pulse_value(pulse_val),
        .i_pulse_a_n(i_pulse_a_n), .i_pulse_b_n(i_pulse_b_n), .o_pulse_out_a(pa), .o_pulse_out_a_oe(pa_oe),
        .o_pulse_out_b(pb), .o_pulse_out_b_oe(pb_oe), .i_irq_req(i_irq_req), .o_irq(irq),
        .o_internal_tick(tick), .o_host_clk_out(hclk), .o_interval_done(done));
    mpr_host_model mpr_host_model_inst (.i_sys_clk(i_sys_clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata));
    task close_out;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [4:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        mpr_host_model_inst.xfer(1'b1, idx, d, r, e);
    endtask : wr
    task rd(input logic [4:0] idx, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        mpr_host_model_inst.xfer(1'b0, idx, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, experr});
    endtask : rd
    // counts cycles in which the chosen output (0 tick, 1 host clock, 2 irq) matched lvl, after it settles
    task automatic count_cyc(input int sel, input logic lvl, input int cyc, input int exp);
        int c;
        logic s;
        c = 0;
        repeat (cyc) begin
            @(posedge i_sys_clk);
            #1;
            s = (sel == 0) ? tick : ((sel == 1) ? hclk : irq);
            if (s === lvl) c++;
        end
        check(c, exp);
    endtask : count_cyc
    task t_regs;
        rd(`MPR_IDX_CONFIG, 32'h000001, 1'b0);
        rd(`MPR_IDX_PAGE, {8'h00, pulse_val}, 1'b0);
        rd(5'h0F, 32'h0, 1'b1);
        wr(`MPR_IDX_PAGE, 32'h1);
        rd(`MPR_IDX_CYCLE_COUNT, {8'h00, `MPR_CYCLE_COUNT_RESET}, 1'b0);
        rd(`MPR_IDX_PAGE, 32'h0, 1'b0);
        wr(`MPR_IDX_CYCLE_COUNT, 32'h2);
        rd(`MPR_IDX_CYCLE_COUNT, 32'h2, 1'b0);
        wr(`MPR_IDX_PAGE, 32'h0);
        rd(`MPR_IDX_CYCLE_COUNT, 32'h0, 1'b1);
    endtask : t_regs
    task t_clock;
        wr(`MPR_IDX_CONFIG, 32'h80981F);
        rd(`MPR_IDX_CONFIG, 32'h80981F, 1'b0);
        wr(`MPR_IDX_CONFIG, 32'h2);
        count_cyc(0, 1'b1, 32, 16);
        wr(`MPR_IDX_CONFIG, 32'h0);
        count_cyc(0, 1'b1, 32, 2);
        wr(`MPR_IDX_CONFIG, 32'h11);
        // the divider still holds its count from K of 16 for one edge
        @(posedge i_sys_clk);
        count_cyc(1, 1'b0, 8, 8);
        wr(`MPR_IDX_CONFIG, 32'h1);
        count_cyc(1, 1'b1, 8, 8);
    endtask : t_clock
    task t_pins;
        repeat (2) @(posedge i_sys_clk);
        #1;
        check({28'h0, pa, pa_oe, pb, pb_oe}, 32'h7);
        wr(`MPR_IDX_CONFIG, 32'h8001);
        repeat (2) @(posedge i_sys_clk);
        #1;
        check({28'h0, pa, pa_oe, pb, pb_oe}, 32'h4);
    endtask : t_pins
    task t_irq;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(`MPR_IDX_CONFIG, 32'h1 | (32'(m) << 11));
            repeat (4) @(posedge i_sys_clk);
            #1;
            check({31'h0, irq}, {31'h0, ~m[0]});
            @(posedge i_sys_clk);
            i_irq_req <= 1'b1;
            // level modes follow one edge later for the whole window, pulse modes give a fixed width
            count_cyc(2, m[0], 40, m[1] ? `MPR_IRQ_PULSE_CYC : 40);
            @(posedge i_sys_clk);
            i_irq_req <= 1'b0;
        end
    endtask : t_irq
    task send(input mpr_chan_smp_type c1, input mpr_chan_smp_type c2);
        @(posedge i_sys_clk);
        i_smp[0] <= c1;
        i_smp[1] <= c2;
        i_smp_valid <= 1'b1;
        @(posedge i_sys_clk);
        i_smp_valid <= 1'b0;
    endtask : send
    task automatic t_samples;
        logic [4:0] ix [16] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h0D,
                                5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h11, 5'h10};
        logic [23:0] ev [16] = '{24'h400000, 24'h400000, 24'h200000, 24'h200000, 24'h800000, 24'h800000,
                                 24'h100000, 24'h100000, 24'h800000, 24'h800000, 24'h7FFFFF, 24'h7FFFFF,
                                 24'hFFFFFF, 24'hFFFFFF, 24'h400000, 24'h400000};
        send({24'h400000, 24'h400000, 24'h200000}, {24'h800000, 24'h800000, 24'hC00000});
        repeat (2) @(posedge i_sys_clk);
        check(n_done, 0);
        send({24'h400000, 24'h400000, 24'h200000}, {24'h800000, 24'h800000, 24'hC00000});
        repeat (2) @(posedge i_sys_clk);
        check(n_done, 1);
        for (int i = 0; i < 16; i++) begin
            rd(ix[i], {8'h00, ev[i]}, 1'b0);
        end
        wr(`MPR_IDX_PWR_CH1, 32'h0);
        rd(`MPR_IDX_PWR_CH1, 32'h200000, 1'b0);
        // half a sample of delay puts channel 1 voltage midway between this and the last sample
        wr(`MPR_IDX_CONFIG, 32'h400001);
        send({24'h400000, 24'h200000, 24'h000000}, '0);
        rd(`MPR_IDX_VOLT_CH1, 32'h300000, 1'b0);
        rd(`MPR_IDX_CUR_CH1, 32'h400000, 1'b0);
    endtask : t_samples
    initial begin
        #(40 * 20000);
        errors++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_regs();
        t_clock();
        t_pins();
        t_irq();
        t_samples();
        close_out();
    end
endmodule : testbench
